// file: exc_seq_pkg.sv
// shared constants and types for the cpu exception sequencer
// Overview of operation
// - reset, interrupt, direct transition, trap in order
// - reset starts on pin rise or watchdog
// - interrupts taken only at instruction/sequence boundaries
// - no interrupt check after ccr ops or reset
// - sleep direct transition uses vector 6 or 12
// - trap instruction uses vectors 8 through 11
// - distinct vectors, four-byte slots at 4n
// - fixed reset, nmi, reserved and internal vectors
// - pin low halts all processing
// - release initialises cpu, peripherals, sets mask
// - reset loads pc from vector slot zero
// - no interrupt before first instruction after reset
// - peripherals except transfer controller start stopped
// - interrupt source vector numbers per pin group
// - nonmaskable interrupt outranks all other interrupts
// - interrupt entry pushes pc and ccr
// - vector fetched, pc loaded, fetch resumes
`default_nettype none
package exc_seq_pkg;
  localparam int unsigned ADDR_W = 24; // advanced-mode address width
  localparam int unsigned VEC_W = 7; // vector numbers 0..119
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [VEC_W-1:0] vec_t;
  // fixed vector numbers
  localparam vec_t VEC_RESET = 7'h00;
  localparam vec_t VEC_DIRECT = 7'h06;
  localparam vec_t VEC_NMI = 7'h07;
  localparam vec_t VEC_TRAP_BASE = 7'h08;
  localparam vec_t VEC_DIRECT_CLK = 7'h0C;
  localparam vec_t VEC_MAX = 7'h77;
  // reserved holes in the table
  localparam vec_t VEC_RSV_A_LO = 7'h01;
  localparam vec_t VEC_RSV_A_HI = 7'h05;
  localparam vec_t VEC_RSV_B_LO = 7'h0D;
  localparam vec_t VEC_RSV_B_HI = 7'h0F;
  localparam vec_t VEC_RSV_C = 7'h20;
  localparam vec_t VEC_IRQ_FIRST = 7'h10; // lowest vector an interrupt may use
  // slot layout and stack frame
  localparam int unsigned VEC_SLOT_SHIFT = 2; // four bytes per slot
  localparam addr_t RESET_VEC_ADDR = 24'h000000;
  localparam addr_t STACK_FRAME_BYTES = 24'h000004; // ccr:pc longword
  localparam int unsigned CCR_I_BIT = 7; // interrupt mask bit of ccr
  // reset pin hold times kept by the reset source
  localparam int unsigned RESET_HOLD_STATES = 20;
  localparam int unsigned POWERON_HOLD_MS = 20;
  // exception causes handed to the vector encoder
  typedef enum logic [2:0] {
    KIND_RESET = 3'h0,
    KIND_NMI = 3'h1,
    KIND_IRQ = 3'h2,
    KIND_DIRECT = 3'h3,
    KIND_DIRECT_CLK = 3'h4,
    KIND_TRAP = 3'h5
  } exc_kind_t;
  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_HALT = 6'h01,
    ST_INIT = 6'h02,
    ST_PUSH = 6'h04,
    ST_VREAD = 6'h08,
    ST_RUN = 6'h10,
    ST_SPARE = 6'h20
  } seq_state_t;
endpackage : exc_seq_pkg
`default_nettype wire

// file: exc_vec_if.sv
// cause-to-vector link between the sequencer and its encoder
`timescale 1ns/1ps
`default_nettype none
interface exc_vec_if;
  exc_seq_pkg::exc_kind_t kind; // cause being served
  logic [1:0] trap_num; // trap source 0..3
  exc_seq_pkg::vec_t irq_vec; // vector offered by the interrupt controller
  exc_seq_pkg::vec_t vec; // vector for kind
  logic vec_ok; // vec is a legal, unreserved number
  logic irq_ok; // irq_vec is a legal interrupt vector
  modport requester (output kind, output trap_num, output irq_vec, input vec, input vec_ok, input irq_ok);
  modport encoder (input kind, input trap_num, input irq_vec, output vec, output vec_ok, output irq_ok);
endinterface : exc_vec_if
`default_nettype wire

// file: exc_vec_encoder.sv
// maps an exception cause to its vector number and checks it
`timescale 1ns/1ps
`default_nettype none
module exc_vec_encoder (
  exc_vec_if.encoder vb
);
  // true for the reserved holes
  function automatic logic is_reserved(input exc_seq_pkg::vec_t v);
    is_reserved = ((v >= exc_seq_pkg::VEC_RSV_A_LO) && (v <= exc_seq_pkg::VEC_RSV_A_HI))
                  || ((v >= exc_seq_pkg::VEC_RSV_B_LO) && (v <= exc_seq_pkg::VEC_RSV_B_HI))
                  || (v == exc_seq_pkg::VEC_RSV_C);
  endfunction : is_reserved

  // fixed table lookup, interrupts pass through the controller's number
  always_comb begin
    unique case (vb.kind)
      exc_seq_pkg::KIND_RESET: vb.vec = exc_seq_pkg::VEC_RESET;
      exc_seq_pkg::KIND_NMI: vb.vec = exc_seq_pkg::VEC_NMI;
      exc_seq_pkg::KIND_DIRECT: vb.vec = exc_seq_pkg::VEC_DIRECT;
      exc_seq_pkg::KIND_DIRECT_CLK: vb.vec = exc_seq_pkg::VEC_DIRECT_CLK;
      exc_seq_pkg::KIND_TRAP: vb.vec = exc_seq_pkg::VEC_TRAP_BASE + exc_seq_pkg::vec_t'(vb.trap_num);
      exc_seq_pkg::KIND_IRQ: vb.vec = vb.irq_vec;
      default: vb.vec = exc_seq_pkg::VEC_RESET; // 3-bit code has unused values
    endcase
    vb.vec_ok = !is_reserved(vb.vec) && (vb.vec <= exc_seq_pkg::VEC_MAX);
    // an interrupt may not borrow a reset, trap or transition slot
    vb.irq_ok = !is_reserved(vb.irq_vec) && (vb.irq_vec >= exc_seq_pkg::VEC_IRQ_FIRST)
                && (vb.irq_vec <= exc_seq_pkg::VEC_MAX);
  end
endmodule : exc_vec_encoder
`default_nettype wire

// file: exc_reset_detect.sv
// reset pin and watchdog overflow detection
`timescale 1ns/1ps
`default_nettype none
module exc_reset_detect (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic reset_in_n_i,
  input wire logic wdt_overflow_i,
  output logic in_reset_o,
  output logic start_o
);
  typedef struct packed {
    logic pin_prev; // pin level one cycle ago
  } det_regs_t;
  det_regs_t r;
  det_regs_t r_nxt;

  // pin level tracking; a low prev after rst_i makes a high pin count as a rise
  always_comb begin
    r_nxt = r;
    r_nxt.pin_prev = reset_in_n_i;
  end

  // register the copy
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign in_reset_o = !reset_in_n_i;
  // rising pin edge or watchdog overflow while the pin is released
  assign start_o = reset_in_n_i && (!r.pin_prev || wdt_overflow_i);
endmodule : exc_reset_detect
`default_nettype wire

// file: cpu_exception_sequencer.sv
// exception sequencer: reset, interrupt, direct transition and trap entry
`timescale 1ns/1ps
`default_nettype none
module cpu_exception_sequencer #(
  parameter int unsigned NUM_MODULES = 16, // peripherals under module stop
  parameter int unsigned DTC_INDEX = 0 // transfer controller's stop bit
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // reset pin and watchdog
  input wire logic reset_in_n_i,
  input wire logic wdt_overflow_i,
  // cpu pipeline boundary
  input wire logic instr_done_i,
  input wire logic ccr_op_done_i,
  input wire logic sleep_direct_i,
  input wire logic sleep_clk_switch_i,
  input wire logic trap_instr_i,
  input wire logic [1:0] trap_num_i,
  input wire logic [23:0] pc_i,
  input wire logic [7:0] cond_code_reg_i,
  input wire logic [23:0] sp_i,
  // interrupt controller
  input wire logic nmi_req_i,
  input wire logic irq_req_i,
  input wire logic [6:0] irq_vec_i,
  // memory port for stack push and vector read
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // software update of module stop
  input wire logic module_stop_wr_i,
  input wire logic [NUM_MODULES-1:0] module_stop_wdata_i,
  // outputs, all registered
  output logic cpu_halt_o,
  output logic periph_init_o,
  output logic ccr_mask_set_o,
  output logic pc_load_o,
  output logic [23:0] pc_value_o,
  output logic sp_dec_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [23:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic int_ack_o,
  output logic [6:0] int_vec_o,
  output logic exc_busy_o,
  output logic [NUM_MODULES-1:0] module_stop_ctrl_o
);
  // module stop value after reset: all stopped but the transfer controller
  localparam logic [NUM_MODULES-1:0] MSTOP_RST = ~(NUM_MODULES'(1) << DTC_INDEX);

  // all sequencer state in one word
  typedef struct packed {
    exc_seq_pkg::seq_state_t state; // sequencer state
    exc_seq_pkg::exc_kind_t kind; // cause being served
    logic [1:0] trap_num; // trap source of a pending trap
    exc_seq_pkg::vec_t irq_vec; // vector of the accepted interrupt
    logic is_reset; // current sequence is the reset one
    logic inhibit; // skip interrupt detection at next boundary
    logic trap_pend; // trap waiting behind an interrupt or a direct transition
    logic dir_pend; // direct transition waiting behind an interrupt
    logic dir_clk; // pending transition is the clock switchover
    logic halt; // cpu held
    logic periph_init; // one-cycle peripheral initialise
    logic ccr_mask_set; // one-cycle set of the ccr mask bit
    logic pc_load; // one-cycle pc load strobe
    exc_seq_pkg::addr_t pc_value; // value for pc load
    logic sp_dec; // one-cycle stack pointer decrement
    logic mem_req; // memory request held until ack
    logic mem_we; // request is the stack push
    exc_seq_pkg::addr_t mem_addr; // request address
    logic [31:0] mem_wdata; // stacked ccr:pc
    logic int_ack; // one-cycle interrupt acknowledge
    exc_seq_pkg::vec_t int_vec; // vector of the acknowledged interrupt
    logic busy; // exception sequence running
    logic [NUM_MODULES-1:0] mstop; // module stop bits
  } seq_regs_t;

  seq_regs_t r;
  seq_regs_t r_nxt;

  logic in_reset; // pin held low
  logic rst_start; // begin the reset sequence

  exc_vec_if vb ();

  // pin edge and watchdog overflow
  exc_reset_detect u_reset_detect (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .reset_in_n_i(reset_in_n_i),
    .wdt_overflow_i(wdt_overflow_i),
    .in_reset_o(in_reset),
    .start_o(rst_start)
  );

  // cause to vector lookup
  exc_vec_encoder u_vec_encoder (
    .vb(vb.encoder)
  );

  // the encoder sees the registered cause, so a vector is ready one cycle after a decision
  assign vb.kind = r.kind;
  assign vb.trap_num = r.trap_num;
  assign vb.irq_vec = irq_vec_i; // checked live while the request is offered

  // byte address of a vector slot, 4n
  function automatic exc_seq_pkg::addr_t slot_addr(input exc_seq_pkg::vec_t v);
    slot_addr = exc_seq_pkg::addr_t'(v) << exc_seq_pkg::VEC_SLOT_SHIFT;
  endfunction : slot_addr

  // next-state logic
  always_comb begin
    logic trap_now; // trap pending, counting one arriving now
    logic dir_now; // transition pending, counting one arriving now
    logic dir_clk_now; // pending transition kind
    logic [1:0] trap_num_now; // pending trap number
    logic int_avail; // an acceptable interrupt is offered
    logic run_edge; // instruction boundary in program execution
    logic seq_end; // end of a non-reset exception sequence
    logic may_int; // interrupt detection allowed at this boundary
    trap_now = 1'b0;
    dir_now = 1'b0;
    dir_clk_now = 1'b0;
    trap_num_now = 2'h0;
    int_avail = 1'b0;
    run_edge = 1'b0;
    seq_end = 1'b0;
    may_int = 1'b0;
    r_nxt = r;
    // strobes last one cycle
    r_nxt.periph_init = 1'b0;
    r_nxt.ccr_mask_set = 1'b0;
    r_nxt.pc_load = 1'b0;
    r_nxt.sp_dec = 1'b0;
    r_nxt.int_ack = 1'b0;

    // software rewrites module stop outside reset
    if (module_stop_wr_i) begin
      r_nxt.mstop = module_stop_wdata_i;
    end

    // collect a trap or transition completing now behind any queued one
    run_edge = (r.state == exc_seq_pkg::ST_RUN) && instr_done_i;
    trap_now = r.trap_pend || (run_edge && trap_instr_i);
    trap_num_now = r.trap_pend ? r.trap_num : trap_num_i;
    dir_now = r.dir_pend || (run_edge && sleep_direct_i);
    dir_clk_now = r.dir_pend ? r.dir_clk : sleep_clk_switch_i;
    seq_end = (r.state == exc_seq_pkg::ST_VREAD) && mem_ack_i && !r.is_reset;
    // the boundary after a ccr op or after reset is skipped
    may_int = (run_edge && !r.inhibit && !ccr_op_done_i) || seq_end;
    // illegal vectors from the controller are never taken
    int_avail = nmi_req_i || (irq_req_i && vb.irq_ok);
    if (run_edge) begin
      // this boundary consumes the one-shot skip; a ccr op is skipped at its own boundary
      r_nxt.inhibit = 1'b0;
    end

    unique case (r.state)
      // pin low: nothing runs
      exc_seq_pkg::ST_HALT: begin
        r_nxt.halt = 1'b1;
        r_nxt.busy = 1'b1;
      end
      // initialise and read slot zero
      exc_seq_pkg::ST_INIT: begin
        r_nxt.periph_init = 1'b1;
        r_nxt.ccr_mask_set = 1'b1;
        r_nxt.mstop = MSTOP_RST;
        r_nxt.halt = 1'b1;
        r_nxt.mem_req = 1'b1;
        r_nxt.mem_we = 1'b0;
        r_nxt.mem_addr = exc_seq_pkg::RESET_VEC_ADDR;
        r_nxt.state = exc_seq_pkg::ST_VREAD;
      end
      // push ccr:pc, then read the vector slot
      exc_seq_pkg::ST_PUSH: begin
        if (mem_ack_i) begin
          r_nxt.sp_dec = 1'b1;
          r_nxt.mem_we = 1'b0;
          // encoder output is valid here: kind was registered at the decision
          r_nxt.mem_addr = slot_addr(vb.vec_ok ? vb.vec : exc_seq_pkg::VEC_RESET);
          r_nxt.state = exc_seq_pkg::ST_VREAD;
        end
      end
      // vector read; its end is a boundary for non-reset sequences
      exc_seq_pkg::ST_VREAD: begin
        if (mem_ack_i) begin
          r_nxt.mem_req = 1'b0;
          r_nxt.pc_value = mem_rdata_i[exc_seq_pkg::ADDR_W-1:0];
          r_nxt.pc_load = 1'b1;
          r_nxt.halt = 1'b0;
          r_nxt.busy = 1'b0;
          r_nxt.state = exc_seq_pkg::ST_RUN;
          if (r.is_reset) begin
            // no interrupt until the first instruction has completed
            r_nxt.inhibit = 1'b1;
            r_nxt.is_reset = 1'b0;
          end
        end
      end
      // program execution; boundaries come from the pipeline
      exc_seq_pkg::ST_RUN: begin
        r_nxt.halt = 1'b0;
      end
      default: begin
        // an illegal code falls back to a halted cpu awaiting reset
        r_nxt.state = exc_seq_pkg::ST_HALT;
        r_nxt.halt = 1'b1;
        r_nxt.busy = 1'b1;
        r_nxt.mem_req = 1'b0;
      end
    endcase

    // choose the next exception at a boundary, interrupts before transitions before traps
    if (run_edge || seq_end) begin
      r_nxt.trap_pend = trap_now;
      r_nxt.trap_num = trap_num_now;
      r_nxt.dir_pend = dir_now;
      r_nxt.dir_clk = dir_clk_now;
      if ((may_int && int_avail) || dir_now || trap_now) begin
        r_nxt.state = exc_seq_pkg::ST_PUSH;
        r_nxt.busy = 1'b1;
        r_nxt.mem_req = 1'b1;
        r_nxt.mem_we = 1'b1;
        r_nxt.mem_addr = sp_i - exc_seq_pkg::STACK_FRAME_BYTES;
        r_nxt.mem_wdata = {cond_code_reg_i, pc_i};
        // a chained entry keeps the pc load of the sequence just ended
        // at a sequence end the pc just loaded is the one to stack
        if (seq_end) begin
          r_nxt.mem_addr = sp_i - exc_seq_pkg::STACK_FRAME_BYTES;
          r_nxt.mem_wdata = {cond_code_reg_i, mem_rdata_i[exc_seq_pkg::ADDR_W-1:0]};
        end
        if (may_int && nmi_req_i) begin
          r_nxt.kind = exc_seq_pkg::KIND_NMI;
          r_nxt.int_ack = 1'b1;
          r_nxt.int_vec = exc_seq_pkg::VEC_NMI;
        end else if (may_int && int_avail) begin
          r_nxt.kind = exc_seq_pkg::KIND_IRQ;
          r_nxt.irq_vec = irq_vec_i;
          r_nxt.int_ack = 1'b1;
          r_nxt.int_vec = irq_vec_i;
        end else if (dir_now) begin
          r_nxt.kind = dir_clk_now ? exc_seq_pkg::KIND_DIRECT_CLK : exc_seq_pkg::KIND_DIRECT;
          r_nxt.dir_pend = 1'b0;
        end else begin
          r_nxt.kind = exc_seq_pkg::KIND_TRAP;
          r_nxt.trap_pend = 1'b0;
        end
      end
    end

    // reset outranks everything: watchdog or pin rise restarts the sequence
    if (rst_start && (r.state != exc_seq_pkg::ST_INIT)) begin
      r_nxt.state = exc_seq_pkg::ST_INIT;
      r_nxt.kind = exc_seq_pkg::KIND_RESET;
      r_nxt.is_reset = 1'b1;
      r_nxt.halt = 1'b1;
      r_nxt.busy = 1'b1;
      r_nxt.mem_req = 1'b0;
      r_nxt.mem_we = 1'b0;
      r_nxt.pc_load = 1'b0;
      r_nxt.sp_dec = 1'b0;
      r_nxt.int_ack = 1'b0;
      r_nxt.trap_pend = 1'b0;
      r_nxt.dir_pend = 1'b0;
      r_nxt.inhibit = 1'b1;
    end

    // pin low wins over all: halt, drop any bus cycle
    if (in_reset) begin
      r_nxt.state = exc_seq_pkg::ST_HALT;
      r_nxt.halt = 1'b1;
      r_nxt.busy = 1'b1;
      r_nxt.mem_req = 1'b0;
      r_nxt.mem_we = 1'b0;
      r_nxt.pc_load = 1'b0;
      r_nxt.sp_dec = 1'b0;
      r_nxt.int_ack = 1'b0;
      r_nxt.periph_init = 1'b0;
      r_nxt.ccr_mask_set = 1'b0;
      r_nxt.trap_pend = 1'b0;
      r_nxt.dir_pend = 1'b0;
      r_nxt.inhibit = 1'b1;
      r_nxt.mstop = MSTOP_RST;
    end
  end

  // register the copy; rst_i behaves like a held pin
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      r <= '0;
      r.state <= exc_seq_pkg::ST_HALT;
      r.kind <= exc_seq_pkg::KIND_RESET;
      r.halt <= 1'b1;
      r.busy <= 1'b1;
      r.inhibit <= 1'b1;
      r.mstop <= MSTOP_RST;
    end else begin
      r <= r_nxt;
    end
  end

  // outputs straight from the state word
  assign cpu_halt_o = r.halt;
  assign periph_init_o = r.periph_init;
  assign ccr_mask_set_o = r.ccr_mask_set;
  assign pc_load_o = r.pc_load;
  assign pc_value_o = r.pc_value;
  assign sp_dec_o = r.sp_dec;
  assign mem_req_o = r.mem_req;
  assign mem_we_o = r.mem_we;
  assign mem_addr_o = r.mem_addr;
  assign mem_wdata_o = r.mem_wdata;
  assign int_ack_o = r.int_ack;
  assign int_vec_o = r.int_vec;
  assign exc_busy_o = r.busy;
  assign module_stop_ctrl_o = r.mstop; // peripherals ignore access while their bit is set
endmodule : cpu_exception_sequencer
`default_nettype wire

// file: mem_responder.sv
// memory partner: answers stack pushes and vector slot reads
`timescale 1ns/1ps
`default_nettype none
module mem_responder (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic [23:0] addr_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [1:0] wait_r; // cycles left before answering
  // one request at a time; a slow partner waits three cycles
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_r <= 2'h0;
      rdata_o <= 32'h5A5A5A5A;
    end else if (!req_i || ack_o) begin
      // idle or just answered: the design moves on next cycle
      ack_o <= 1'b0;
      wait_r <= {slow_i, slow_i};
      rdata_o <= ~rdata_o; // released bus never shows the old word
    end else if (wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
      rdata_o <= ~rdata_o;
    end else begin
      ack_o <= 1'b1;
      rdata_o <= {8'hA5, 24'h100000 | addr_i}; // slot holds base plus its address
    end
  end
endmodule : mem_responder
`default_nettype wire

// file: cpu_exception_sequencer_checker.sv
// port-level assertions for the cpu exception sequencer
`timescale 1ns/1ps
`default_nettype none
module exc_seq_checker #(
  parameter int unsigned NUM_MODULES = 16, // peripherals under module stop
  parameter int unsigned DTC_INDEX = 0 // transfer controller's stop bit
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic reset_in_n_i,
  input wire logic wdt_overflow_i,
  input wire logic instr_done_i,
  input wire logic ccr_op_done_i,
  input wire logic nmi_req_i,
  input wire logic irq_req_i,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic cpu_halt_o,
  input wire logic periph_init_o,
  input wire logic ccr_mask_set_o,
  input wire logic pc_load_o,
  input wire logic [23:0] pc_value_o,
  input wire logic sp_dec_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic int_ack_o,
  input wire logic [6:0] int_vec_o,
  input wire logic exc_busy_o,
  input wire logic [NUM_MODULES-1:0] module_stop_ctrl_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic first_r; // next boundary is the first after a reset sequence
  logic [23:0] rd_addr; // start address carried by the read word
  assign rd_addr = mem_rdata_i[23:0];
  // the reset sequence's vector read ends while the cpu is still held
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      first_r <= 1'b0;
    end else if (cpu_halt_o && mem_req_o && mem_ack_i) begin
      first_r <= 1'b1;
    end else if (instr_done_i) begin
      first_r <= 1'b0;
    end
  end
  sequence init_step; // first visible step of a reset sequence
    periph_init_o && ccr_mask_set_o && mem_req_o && !mem_we_o && mem_addr_o == 24'h000000;
  endsequence
  sequence read_done; // vector slot read answered
    mem_req_o && !mem_we_o && mem_ack_i;
  endsequence
  sequence write_done; // stack push answered
    mem_req_o && mem_we_o && mem_ack_i;
  endsequence
  chk_pin_halt: assert property (!reset_in_n_i |=> cpu_halt_o && !mem_req_o && !pc_load_o)
    else $error("pin low did not hold the cpu");
  chk_pin_start: assert property ($rose(reset_in_n_i) |-> ##2 init_step)
    else $error("pin release did not start reset");
  chk_wdt_start: assert property (wdt_overflow_i && reset_in_n_i && !cpu_halt_o |-> ##2 init_step)
    else $error("watchdog did not start reset");
  chk_stop_init: assert property (periph_init_o |-> module_stop_ctrl_o == ~(NUM_MODULES'(1) << DTC_INDEX))
    else $error("module stop not initialised");
  chk_halt_end: assert property (read_done ##0 cpu_halt_o |=> pc_load_o && !cpu_halt_o && !exc_busy_o)
    else $error("reset sequence did not hand over");
  chk_vec_to_pc: assert property (read_done ##0 (!nmi_req_i && !irq_req_i) |=> pc_load_o && pc_value_o == $past(rd_addr))
    else $error("pc not loaded from slot");
  chk_push_read: assert property (write_done |=> sp_dec_o && mem_req_o && !mem_we_o)
    else $error("push not followed by slot read");
  chk_nmi_take: assert property (instr_done_i && nmi_req_i && !ccr_op_done_i && !first_r && !exc_busy_o
    |=> int_ack_o && int_vec_o == 7'h07 && mem_req_o && mem_we_o)
    else $error("nmi not taken at boundary");
  chk_logic_op_skip: assert property (instr_done_i && ccr_op_done_i |=> !int_ack_o)
    else $error("interrupt taken after flag op");
  chk_reset_skip: assert property (instr_done_i && first_r |=> !int_ack_o)
    else $error("interrupt taken after reset");
  chk_vec_legal: assert property (int_ack_o |-> int_vec_o == 7'h07 || int_vec_o inside {[7'h10:7'h1F], [7'h21:7'h77]})
    else $error("reserved vector accepted");
  chk_slot_addr: assert property (mem_req_o && !mem_we_o |-> mem_addr_o[1:0] == 2'h0 && mem_addr_o < 24'h0001E0)
    else $error("slot address malformed");
endmodule : exc_seq_checker
bind cpu_exception_sequencer exc_seq_checker #(.NUM_MODULES(NUM_MODULES), .DTC_INDEX(DTC_INDEX)) i_exc_seq_checker (.*);
`default_nettype wire

// file: cpu_exception_sequencer_tb.sv
// self-checking bench for the cpu exception sequencer
`timescale 1ns/1ps
`default_nettype none
module cpu_exception_sequencer_tb;
  localparam logic [23:0] BASE = 24'h100000; // partner's handler base
  logic clk_sys_i = 1'b0; // 20 MHz
  logic rst_i = 1'b1;
  logic reset_in_n_i = 1'b0; // pin low at power-on
  logic wdt_overflow_i = 1'b0, instr_done_i = 1'b0, ccr_op_done_i = 1'b0, slow = 1'b0;
  logic sleep_direct_i = 1'b0, sleep_clk_switch_i = 1'b0, trap_instr_i = 1'b0;
  logic nmi_req_i = 1'b0, irq_req_i = 1'b0, module_stop_wr_i = 1'b0;
  logic [1:0] trap_num_i = 2'h0;
  logic [6:0] irq_vec_i = 7'h10;
  logic [23:0] pc_i = 24'h001234, sp_i = 24'h00FF80; // stack valid from the first instruction
  logic [7:0] cond_code_reg_i = 8'h05;
  logic [15:0] module_stop_wdata_i = 16'h0000;
  logic mem_ack_i, cpu_halt_o, periph_init_o, ccr_mask_set_o, pc_load_o, sp_dec_o, mem_req_o, mem_we_o;
  logic int_ack_o, exc_busy_o;
  logic [23:0] pc_value_o, mem_addr_o;
  logic [31:0] mem_rdata_i, mem_wdata_o;
  logic [6:0] int_vec_o;
  logic [15:0] module_stop_ctrl_o;
  int mismatches = 0, comparisons = 0;
  logic ack = 1'b0; // ack seen in the answer cycle
  logic [6:0] vec; // last accepted vector
  logic [23:0] pc; // last loaded start address
  always #25 clk_sys_i = ~clk_sys_i;
  cpu_exception_sequencer i_cpu_exception_sequencer (.*);
  mem_responder i_mem_responder (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slow_i(slow), .req_i(mem_req_o),
    .addr_i(mem_addr_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check
  // one boundary with qualifiers {flag op, direct, clock switch, trap}
  task automatic boundary(input logic [3:0] kind, input logic [1:0] num);
    @(posedge clk_sys_i);
    {ccr_op_done_i, sleep_direct_i, sleep_clk_switch_i, trap_instr_i} <= kind;
    trap_num_i <= num;
    instr_done_i <= 1'b1;
    pc_i <= pc_i + 24'h000010;
    @(posedge clk_sys_i);
    {instr_done_i, ccr_op_done_i, sleep_direct_i, sleep_clk_switch_i, trap_instr_i} <= 5'h00;
    #1;
    ack = int_ack_o;
    vec = int_vec_o;
  endtask : boundary
  // follow a sequence until the cpu runs again; requests drop once answered
  task automatic settle();
    pc = 24'hFFFFFF;
    for (int n = 0; n < 80; n++) begin
      @(posedge clk_sys_i);
      if (ack === 1'b1 && vec === 7'h07) nmi_req_i <= 1'b0;
      else if (ack === 1'b1) irq_req_i <= 1'b0;
      #1;
      ack = int_ack_o;
      if (ack === 1'b1) vec = int_vec_o;
      if (pc_load_o === 1'b1) pc = pc_value_o;
      if (exc_busy_o === 1'b0 && cpu_halt_o === 1'b0) return;
    end
    check(1'b0, "sequence did not finish");
  endtask : settle
  task automatic t_power_on();
    repeat (20) @(posedge clk_sys_i); // hold shortened to keep the run short
    reset_in_n_i <= 1'b1;
    settle();
    check(pc === BASE && module_stop_ctrl_o === 16'hFFFE, "power-on start wrong");
    $display("test power_on done");
  endtask : t_power_on
  task automatic t_inhibit();
    @(posedge clk_sys_i);
    nmi_req_i <= 1'b1;
    irq_req_i <= 1'b1;
    boundary(4'h0, 2'h0);
    check(ack === 1'b0, "interrupt right after reset");
    boundary(4'h8, 2'h0);
    check(ack === 1'b0, "interrupt after flag op");
    boundary(4'h0, 2'h0);
    check(ack === 1'b1 && vec === 7'h07, "nmi not first");
    settle();
    check(vec === 7'h10 && pc === (BASE | 24'h000040), "chained request lost");
    $display("test inhibit done");
  endtask : t_inhibit
  task automatic t_vectors();
    logic [3:0] kinds [6] = '{4'h4, 4'h6, 4'h1, 4'h1, 4'h1, 4'h1};
    logic [6:0] exp [6] = '{7'h06, 7'h0C, 7'h08, 7'h09, 7'h0A, 7'h0B};
    @(posedge clk_sys_i);
    slow <= 1'b1; // partner answers late
    for (int i = 0; i < 6; i++) begin
      boundary(kinds[i], 2'(i - 2));
      check(ack === 1'b0 && exc_busy_o === 1'b1, "entry not started");
      settle();
      check(pc === (BASE | {15'h0000, exp[i], 2'h0}), "wrong vector slot");
    end
    $display("test vectors done");
  endtask : t_vectors
  task automatic t_priority();
    @(posedge clk_sys_i);
    irq_req_i <= 1'b1;
    irq_vec_i <= 7'h77;
    slow <= 1'b0;
    boundary(4'h1, 2'h0);
    check(ack === 1'b1 && vec === 7'h77, "interrupt not ahead of trap");
    settle();
    check(pc === (BASE | 24'h000020), "queued trap lost");
    @(posedge clk_sys_i);
    irq_req_i <= 1'b1;
    irq_vec_i <= 7'h20;
    boundary(4'h0, 2'h0);
    check(ack === 1'b0 && exc_busy_o === 1'b0, "reserved vector taken");
    @(posedge clk_sys_i);
    irq_req_i <= 1'b0;
    $display("test priority done");
  endtask : t_priority
  task automatic t_restart();
    @(posedge clk_sys_i);
    module_stop_wr_i <= 1'b1;
    module_stop_wdata_i <= 16'h00F0;
    @(posedge clk_sys_i);
    module_stop_wr_i <= 1'b0;
    wdt_overflow_i <= 1'b1;
    @(posedge clk_sys_i);
    wdt_overflow_i <= 1'b0;
    settle();
    check(pc === BASE && module_stop_ctrl_o === 16'hFFFE, "watchdog reset wrong");
    @(posedge clk_sys_i);
    reset_in_n_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i); // minimum hold in operation
    #1;
    check(cpu_halt_o === 1'b1 && mem_req_o === 1'b0, "pin low did not halt");
    @(posedge clk_sys_i);
    reset_in_n_i <= 1'b1;
    settle();
    check(pc === BASE, "pin reset vector wrong");
    $display("test restart done");
  endtask : t_restart
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    check(cpu_halt_o === 1'b1 && module_stop_ctrl_o === 16'hFFFE, "reset state wrong");
    t_power_on();
    t_inhibit();
    t_vectors();
    t_priority();
    t_restart();
    close_out();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(50 * 4000);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
endmodule : cpu_exception_sequencer_tb
`default_nettype wire
